/* File: ipsk_pkg.sv */
// Constants, types and decode helpers shared by the serial and keyboard port path.
package ipsk_pkg;

   // -------------------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int DEF_CLK_HZ = 1_000_000_000 / CLK_PERIOD_NS;
   localparam int OVERSAMPLE = 16;
   localparam int DIV_W = 18;
   localparam int BAUD_MIN = 75;
   localparam int BAUD_MAX = 9600;
   localparam logic [3:0] MID_TICK = 4'h7;
   localparam logic [3:0] LAST_TICK = 4'hF;

   // -------------------------------------------------------------------------
   // Character layout
   // -------------------------------------------------------------------------
   localparam int DATA_BITS = 8;
   localparam int CODE_BITS = 7;
   localparam int KEY_LINES = 64;
   localparam int KEY_IDX_W = 6;
   localparam int FRAME_BITS = 10;
   localparam logic [7:0] BUS_IDLE = 8'h00;

   // -------------------------------------------------------------------------
   // Status word bit positions
   // -------------------------------------------------------------------------
   localparam int ST_RX_READY = 0;
   localparam int ST_TX_READY = 1;
   localparam int ST_OVERRUN = 2;
   localparam int ST_FRAMING = 3;
   localparam int KB_READY_BIT = 7;

   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_DATA = 2'b10,
      RX_STOP = 2'b11
   } ipsk_rx_state_t;

   // Baud select code to rate; unknown codes fall back to the fastest rate.
   function automatic int baud_rate(input logic [3:0] sel);
      case (sel)
         4'h0: return BAUD_MIN;
         4'h1: return 110;
         4'h2: return 150;
         4'h3: return 300;
         4'h4: return 600;
         4'h5: return 1200;
         4'h6: return 2400;
         4'h7: return 4800;
         4'h8: return BAUD_MAX;
         default: return BAUD_MAX;
      endcase
   endfunction

endpackage

/* File: ipsk_term.sv */
// Serial terminal model that faces the serial connector of the port path.
`timescale 1ns/100ps
module ipsk_term (
   // Clock
   input wire logic sys_clk,
   // Serial lines
   input wire logic txd,
   output logic rxd
);
   int bit_cyc = 160;
   logic [7:0] got_byte = 8'h00;
   logic got_stop = 1'b0;
   int got_count = 0;

   initial rxd = 1'b1;

   // -------------------------------------------------------------------------
   // Transmit toward the block
   // -------------------------------------------------------------------------
   // One frame: start bit, eight data bits low first, then the given stop level.
   task automatic send(input logic [7:0] d, input logic stop_lvl);
      logic [9:0] frame;
      frame = {stop_lvl, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge sys_clk);
         rxd <= frame[i];
         repeat (bit_cyc - 1) @(posedge sys_clk);
      end
      @(posedge sys_clk);
      rxd <= 1'b1;
   endtask

   // -------------------------------------------------------------------------
   // Receive from the block
   // -------------------------------------------------------------------------
   // Samples mid-bit, just after the edge, so the sample never races the pin update.
   always begin
      @(negedge txd);
      repeat (bit_cyc / 2) @(posedge sys_clk);
      #1;
      if (txd === 1'b0) begin
         for (int i = 0; i < 8; i++) begin
            repeat (bit_cyc) @(posedge sys_clk);
            #1;
            got_byte[i] = txd;
         end
         repeat (bit_cyc) @(posedge sys_clk);
         #1;
         got_stop = txd;
         got_count++;
      end
   end
endmodule

/* File: ipsk_top.sv */
// Keyboard port, data input selector and serial channel of the programmed I/O path.
`timescale 1ns/100ps
module ipsk_top
   import ipsk_pkg::*;
#(
   parameter int CLK_HZ = DEF_CLK_HZ
)(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Decoded port strobes, one per read or write cycle
   input wire logic kbd_data_rd,
   input wire logic kbd_stat_rd,
   input wire logic ser_data_rd,
   input wire logic ser_stat_rd,
   input wire logic ser_data_wr,
   // Processor buses
   input wire logic [7:0] dio_out,
   input wire logic [7:0] ext_din,
   output logic [7:0] cpu_din,
   output logic [7:0] int_bus,
   output logic int_bus_oe,
   // Keyboard and serial connector pins
   input wire logic [KEY_LINES-1:0] key_lines,
   input wire logic key_shift,
   input wire logic [3:0] baud_sel,
   input wire logic rxd,
   output logic txd
);

   ipsk_tx_if tif ();

   logic [KEY_LINES-1:0] keys_s1_r, keys_s2_r;
   logic shift_s1_r, shift_s2_r;
   logic [3:0] baud_s1_r, baud_s2_r;
   logic rxd_s1_r, rxd_s2_r;
   logic any_key_prev_r;
   logic key_rise;
   logic [CODE_BITS-1:0] kbd_code_r;
   logic kbd_ready_r;
   logic [DIV_W-1:0] div_cnt_r;
   logic [DIV_W-1:0] div_max;
   logic tick16_r;
   ipsk_rx_state_t rx_state_r;
   logic [3:0] rx_tick_r;
   logic [2:0] rx_bit_r;
   logic [DATA_BITS-1:0] rx_sh_r, rx_hold_r;
   logic rx_done_r, rx_ready_r, overrun_r, framing_r;
   logic [7:0] status;
   logic int_sel;
   logic [7:0] int_val;
   logic [7:0] cpu_din_r, int_bus_r;
   logic int_bus_oe_r;

   // Lowest pressed key line gives the six low bits of the code.
   function automatic logic [KEY_IDX_W-1:0] key_index(input logic [KEY_LINES-1:0] k);
      logic [KEY_IDX_W-1:0] idx;
      idx = '0;
      for (int i = KEY_LINES - 1; i >= 0; i--) begin
         if (k[i]) begin
            idx = KEY_IDX_W'(i);
         end
      end
      return idx;
   endfunction

   // -------------------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         keys_s1_r <= '0;
         keys_s2_r <= '0;
         shift_s1_r <= 1'b0;
         shift_s2_r <= 1'b0;
         baud_s1_r <= 4'h0;
         baud_s2_r <= 4'h0;
         rxd_s1_r <= 1'b1;
         rxd_s2_r <= 1'b1;
      end else begin
         keys_s1_r <= key_lines;
         keys_s2_r <= keys_s1_r;
         shift_s1_r <= key_shift;
         shift_s2_r <= shift_s1_r;
         baud_s1_r <= baud_sel;
         baud_s2_r <= baud_s1_r;
         rxd_s1_r <= rxd;
         rxd_s2_r <= rxd_s1_r;
      end
   end

   // -------------------------------------------------------------------------
   // Keyboard port
   // -------------------------------------------------------------------------
   assign key_rise = (|keys_s2_r) && !any_key_prev_r;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         any_key_prev_r <= 1'b0;
         kbd_code_r <= '0;
      end else begin
         any_key_prev_r <= |keys_s2_r;
         if (key_rise) begin
            kbd_code_r <= {shift_s2_r, key_index(keys_s2_r)};
         end
      end
   end

   // A new key wins over a read clearing the flag in the same cycle.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         kbd_ready_r <= 1'b0;
      end else if (key_rise) begin
         kbd_ready_r <= 1'b1;
      end else if (kbd_data_rd) begin
         kbd_ready_r <= 1'b0;
      end
   end

   // -------------------------------------------------------------------------
   // Baud generator: one-cycle pulse at sixteen times the bit rate
   // -------------------------------------------------------------------------
   assign div_max = DIV_W'(CLK_HZ / (OVERSAMPLE * baud_rate(baud_s2_r)) - 1);

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         div_cnt_r <= '0;
         tick16_r <= 1'b0;
      end else if (div_cnt_r >= div_max) begin
         div_cnt_r <= '0;
         tick16_r <= 1'b1;
      end else begin
         div_cnt_r <= div_cnt_r + 1'b1;
         tick16_r <= 1'b0;
      end
   end

   // -------------------------------------------------------------------------
   // Serial receiver
   // -------------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_state_r <= RX_IDLE;
         rx_tick_r <= 4'h0;
         rx_bit_r <= 3'h0;
         rx_sh_r <= '0;
         rx_hold_r <= '0;
         rx_done_r <= 1'b0;
         framing_r <= 1'b0;
      end else begin
         rx_done_r <= 1'b0;
         case (rx_state_r)
            RX_IDLE: begin
               rx_tick_r <= 4'h0;
               if (!rxd_s2_r) begin
                  rx_state_r <= RX_START;
               end
            end
            RX_START: begin
               if (tick16_r) begin
                  rx_tick_r <= rx_tick_r + 4'h1;
                  if (rx_tick_r == MID_TICK) begin
                     rx_tick_r <= 4'h0;
                     rx_bit_r <= 3'h0;
                     rx_state_r <= rxd_s2_r ? RX_IDLE : RX_DATA;
                  end
               end
            end
            RX_DATA: begin
               if (tick16_r) begin
                  rx_tick_r <= rx_tick_r + 4'h1;
                  if (rx_tick_r == LAST_TICK) begin
                     rx_sh_r <= {rxd_s2_r, rx_sh_r[DATA_BITS-1:1]};
                     rx_bit_r <= rx_bit_r + 3'h1;
                     if (rx_bit_r == 3'(DATA_BITS - 1)) begin
                        rx_state_r <= RX_STOP;
                     end
                  end
               end
            end
            RX_STOP: begin
               if (tick16_r) begin
                  rx_tick_r <= rx_tick_r + 4'h1;
                  if (rx_tick_r == LAST_TICK) begin
                     rx_hold_r <= rx_sh_r;
                     framing_r <= !rxd_s2_r;
                     rx_done_r <= 1'b1;
                     rx_state_r <= RX_IDLE;
                  end
               end
            end
            default: rx_state_r <= RX_IDLE;
         endcase
      end
   end

   // Arrival wins over a data read in the same cycle.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_ready_r <= 1'b0;
         overrun_r <= 1'b0;
      end else begin
         if (rx_done_r) begin
            rx_ready_r <= 1'b1;
         end else if (ser_data_rd) begin
            rx_ready_r <= 1'b0;
         end
         if (rx_done_r && rx_ready_r) begin
            overrun_r <= 1'b1;
         end else if (ser_data_rd) begin
            overrun_r <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Transmitter connection
   // -------------------------------------------------------------------------
   assign tif.tick = tick16_r;
   assign tif.load = ser_data_wr;
   assign tif.data = dio_out;
   assign txd = tif.txd;

   ipsk_tx u_tx (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .tif(tif)
   );

   // -------------------------------------------------------------------------
   // Internal data bus and data input selector
   // -------------------------------------------------------------------------
   always_comb begin
      status = BUS_IDLE;
      status[ST_RX_READY] = rx_ready_r;
      status[ST_TX_READY] = tif.hold_free;
      status[ST_OVERRUN] = overrun_r;
      status[ST_FRAMING] = framing_r;
      int_sel = ser_data_rd || ser_stat_rd || kbd_stat_rd;
      int_val = BUS_IDLE;
      if (ser_data_rd) begin
         int_val = rx_hold_r;
      end else if (ser_stat_rd) begin
         int_val = status;
      end else if (kbd_stat_rd) begin
         int_val[KB_READY_BIT] = kbd_ready_r;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         int_bus_r <= BUS_IDLE;
         int_bus_oe_r <= 1'b0;
      end else begin
         int_bus_r <= int_val;
         int_bus_oe_r <= int_sel;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cpu_din_r <= BUS_IDLE;
      end else if (kbd_data_rd) begin
         cpu_din_r <= {1'b0, kbd_code_r};
      end else if (int_sel) begin
         cpu_din_r <= int_val;
      end else begin
         cpu_din_r <= ext_din;
      end
   end

   assign cpu_din = cpu_din_r;
   assign int_bus = int_bus_r;
   assign int_bus_oe = int_bus_oe_r;

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   kbd_code_load_a: assert property (key_rise |=> kbd_code_r == {$past(shift_s2_r), $past(key_index(keys_s2_r))})
      else $error("keyboard code not captured on new key");
   kbd_flag_set_a: assert property (key_rise |=> kbd_ready_r)
      else $error("keyboard ready flag not raised");
   kbd_select_a: assert property (kbd_data_rd |=> cpu_din_r == {1'b0, $past(kbd_code_r)})
      else $error("keyboard code not routed to processor input");
   rx_ready_set_a: assert property (rx_done_r |-> rx_state_r == RX_IDLE ##1 rx_ready_r)
      else $error("received data ready not raised");
   rx_ready_clear_a: assert property (ser_data_rd && !rx_done_r |=> !rx_ready_r)
      else $error("received data ready not cleared by data read");
   ser_data_route_a: assert property (ser_data_rd |=> int_bus_oe_r && cpu_din_r == int_bus_r && int_bus_r == $past(rx_hold_r))
      else $error("received word not routed over internal bus");
   stat_one_cycle_a: assert property (ser_stat_rd ##1 !int_sel |-> int_bus_r == $past(status) ##1 !int_bus_oe_r)
      else $error("status not driven for exactly the strobed read");
   bus_float_a: assert property (!int_sel |=> !int_bus_oe_r)
      else $error("internal bus driven without a port strobe");
   baud_tick_gap_a: assert property (tick16_r && div_max != '0 |=> !tick16_r)
      else $error("baud tick not a single cycle pulse");

endmodule

/* File: ipsk_top_tb.sv */
// Self-checking testbench of the keyboard and serial port path.
`timescale 1ns/100ps
module ipsk_top_tb
   import ipsk_pkg::*;
;
   localparam int SIM_CLK_HZ = 1_536_000;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic kbd_data_rd = 1'b0, kbd_stat_rd = 1'b0, ser_data_rd = 1'b0, ser_stat_rd = 1'b0;
   logic ser_data_wr = 1'b0;
   logic [7:0] dio_out = 8'h00, ext_din = 8'h00;
   logic [7:0] cpu_din, int_bus, rd_d, rd_b;
   logic int_bus_oe, txd, rxd, rd_oe;
   logic [KEY_LINES-1:0] key_lines = '0;
   logic key_shift = 1'b0;
   logic [3:0] baud_sel = 4'h8;
   int num_errors = 0;
   int total_checks = 0;
   int n;

   always #2.5 sys_clk = ~sys_clk;

   ipsk_top #(.CLK_HZ(SIM_CLK_HZ)) i_ipsk_top (.sys_clk(sys_clk), .arst_n(arst_n),
      .kbd_data_rd(kbd_data_rd), .kbd_stat_rd(kbd_stat_rd), .ser_data_rd(ser_data_rd),
      .ser_stat_rd(ser_stat_rd), .ser_data_wr(ser_data_wr), .dio_out(dio_out),
      .ext_din(ext_din), .cpu_din(cpu_din), .int_bus(int_bus), .int_bus_oe(int_bus_oe),
      .key_lines(key_lines), .key_shift(key_shift), .baud_sel(baud_sel), .rxd(rxd),
      .txd(txd));

   ipsk_term i_ipsk_term (.sys_clk(sys_clk), .txd(txd), .rxd(rxd));

   // -------------------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------------------
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One read cycle: 0 keyboard data, 1 keyboard status, 2 serial data, 3 serial status.
   task automatic rd(input int sel);
      @(posedge sys_clk);
      case (sel)
         0: kbd_data_rd <= 1'b1;
         1: kbd_stat_rd <= 1'b1;
         2: ser_data_rd <= 1'b1;
         default: ser_stat_rd <= 1'b1;
      endcase
      @(posedge sys_clk);
      {kbd_data_rd, kbd_stat_rd, ser_data_rd, ser_stat_rd} <= 4'h0;
      #1;
      rd_d = cpu_din;
      rd_b = int_bus;
      rd_oe = int_bus_oe;
   endtask

   task automatic wr(input logic [7:0] d);
      @(posedge sys_clk);
      ser_data_wr <= 1'b1;
      dio_out <= d;
      @(posedge sys_clk);
      ser_data_wr <= 1'b0;
   endtask

   task automatic end_sim;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // -------------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------------
   task automatic t_reset;
      #1;
      chk_bit(int_bus_oe, 1'b0);
      chk_byte(int_bus, 8'h00);
      chk_byte(cpu_din, 8'h00);
      chk_bit(txd, 1'b1);
      @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
   endtask

   task automatic t_idle;
      ext_din <= 8'h3C;
      repeat (3) @(posedge sys_clk);
      #1;
      chk_bit(int_bus_oe, 1'b0);
      chk_byte(int_bus, 8'h00);
      chk_byte(cpu_din, 8'h3C);
   endtask

   // Lines 1 and 5 pressed with shift: the lower line gives the code.
   task automatic t_keyboard;
      @(posedge sys_clk);
      key_lines <= 64'h22;
      key_shift <= 1'b1;
      repeat (6) @(posedge sys_clk);
      rd(1);
      chk_bit(rd_oe, 1'b1);
      chk_bit(rd_b[KB_READY_BIT], 1'b1);
      rd(0);
      chk_byte(rd_d, 8'h41);
      rd(1);
      chk_bit(rd_b[KB_READY_BIT], 1'b0);
      @(posedge sys_clk);
      key_lines <= '0;
      key_shift <= 1'b0;
   endtask

   task automatic t_status;
      rd(3);
      chk_bit(rd_oe, 1'b1);
      chk_bit(rd_b[ST_TX_READY], 1'b1);
      chk_bit(rd_b[ST_RX_READY], 1'b0);
      chk_byte(rd_b, 8'h02);
      chk_byte(rd_d, 8'h02);
      @(posedge sys_clk);
      #1;
      chk_bit(int_bus_oe, 1'b0);
      chk_byte(int_bus, 8'h00);
   endtask

   // A second write one cycle after the first meets a full holding register.
   task automatic t_tx;
      rd(3);
      chk_bit(rd_b[ST_TX_READY], 1'b1);
      n = i_ipsk_term.got_count;
      @(posedge sys_clk);
      ser_data_wr <= 1'b1;
      dio_out <= 8'hA5;
      @(posedge sys_clk);
      dio_out <= 8'h3C;
      ser_stat_rd <= 1'b1;
      @(posedge sys_clk);
      ser_data_wr <= 1'b0;
      ser_stat_rd <= 1'b0;
      #1;
      chk_bit(int_bus[ST_TX_READY], 1'b0);
      rd(3);
      chk_bit(rd_b[ST_TX_READY], 1'b1);
      repeat (3400) @(posedge sys_clk);
      chk_byte(i_ipsk_term.got_byte, 8'hA5);
      chk_bit(i_ipsk_term.got_stop, 1'b1);
      chk_byte(8'(i_ipsk_term.got_count - n), 8'h01);
   endtask

   task automatic t_baud;
      @(posedge sys_clk);
      baud_sel <= 4'h7;
      i_ipsk_term.bit_cyc = 320;
      repeat (8) @(posedge sys_clk);
      rd(3);
      chk_bit(rd_b[ST_TX_READY], 1'b1);
      wr(8'hC3);
      repeat (3400) @(posedge sys_clk);
      chk_byte(i_ipsk_term.got_byte, 8'hC3);
      baud_sel <= 4'h8;
      i_ipsk_term.bit_cyc = 160;
      repeat (8) @(posedge sys_clk);
   endtask

   task automatic t_rx;
      i_ipsk_term.send(8'h5A, 1'b1);
      repeat (20) @(posedge sys_clk);
      rd(3);
      chk_bit(rd_b[ST_RX_READY], 1'b1);
      chk_bit(rd_b[ST_FRAMING], 1'b0);
      rd(2);
      chk_byte(rd_d, 8'h5A);
      chk_byte(rd_b, 8'h5A);
      chk_bit(rd_oe, 1'b1);
      rd(3);
      chk_bit(rd_b[ST_RX_READY], 1'b0);
   endtask

   // Two unread characters, then one with a broken stop bit.
   task automatic t_rx_err;
      i_ipsk_term.send(8'h11, 1'b1);
      i_ipsk_term.send(8'h22, 1'b1);
      repeat (20) @(posedge sys_clk);
      rd(3);
      chk_bit(rd_b[ST_OVERRUN], 1'b1);
      rd(2);
      chk_byte(rd_d, 8'h22);
      rd(3);
      chk_bit(rd_b[ST_OVERRUN], 1'b0);
      chk_bit(rd_b[ST_RX_READY], 1'b0);
      i_ipsk_term.send(8'h33, 1'b0);
      repeat (200) @(posedge sys_clk);
      rd(3);
      chk_bit(rd_b[ST_FRAMING], 1'b1);
      rd(2);
      chk_byte(rd_d, 8'h33);
   endtask

   // -------------------------------------------------------------------------
   // Sequence and watchdog
   // -------------------------------------------------------------------------
   initial begin
      repeat (20) @(posedge sys_clk);
      t_reset;
      t_idle;
      t_keyboard;
      t_status;
      t_tx;
      t_baud;
      t_rx;
      t_rx_err;
      end_sim;
   end

   initial begin
      repeat (40000) @(posedge sys_clk);
      num_errors++;
      end_sim;
   end
endmodule

/* File: ipsk_tx.sv */
// Serial transmitter with a holding register and a shift register.
`timescale 1ns/100ps
module ipsk_tx
   import ipsk_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Control side
   ipsk_tx_if.tx tif
);

   logic [DATA_BITS-1:0] hold_r;
   logic hold_full_r;
   logic [FRAME_BITS-1:0] sh_r;
   logic busy_r;
   logic [3:0] tick_r;
   logic [3:0] bit_r;
   logic txd_r;
   logic take;

   // A load is ignored while the holding register is still full.
   assign take = tif.load && !hold_full_r;
   assign tif.hold_free = !hold_full_r;
   assign tif.txd = txd_r;

   // -------------------------------------------------------------------------
   // Holding register
   // -------------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         hold_r <= BUS_IDLE;
         hold_full_r <= 1'b0;
      end else if (take) begin
         hold_r <= tif.data;
         hold_full_r <= 1'b1;
      end else if (!busy_r && hold_full_r) begin
         hold_full_r <= 1'b0;
      end
   end

   // -------------------------------------------------------------------------
   // Shifter: start bit, eight data bits LSB first, one stop bit
   // -------------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         sh_r <= '1;
         busy_r <= 1'b0;
         tick_r <= 4'h0;
         bit_r <= 4'h0;
      end else if (!busy_r) begin
         if (hold_full_r) begin
            sh_r <= {1'b1, hold_r, 1'b0};
            busy_r <= 1'b1;
            tick_r <= 4'h0;
            bit_r <= 4'h0;
         end
      end else if (tif.tick) begin
         tick_r <= tick_r + 4'h1;
         if (tick_r == LAST_TICK) begin
            sh_r <= {1'b1, sh_r[FRAME_BITS-1:1]};
            bit_r <= bit_r + 4'h1;
            if (bit_r == 4'(FRAME_BITS - 1)) begin
               busy_r <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         txd_r <= 1'b1;
      end else begin
         txd_r <= busy_r ? sh_r[0] : 1'b1;
      end
   end

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   sequence tx_frame_start_s;
      !busy_r ##1 busy_r;
   endsequence

   tx_load_busy_a: assert property (take |=> !tif.hold_free && hold_r == $past(tif.data))
      else $error("transmit load did not fill the holding register");
   tx_start_bit_a: assert property (tx_frame_start_s |=> !txd_r)
      else $error("transmit frame did not begin with a start bit");
   tx_ready_back_a: assert property (!busy_r && hold_full_r && !take |=> tif.hold_free)
      else $error("transmitter ready did not return after transfer to shifter");

endmodule

/* File: ipsk_tx_if.sv */
// Link between the port path top and its serial transmitter.
`timescale 1ns/100ps
interface ipsk_tx_if;
   logic tick;
   logic load;
   logic [7:0] data;
   logic hold_free;
   logic txd;

   modport ctrl (
      output tick,
      output load,
      output data,
      input hold_free,
      input txd
   );
   modport tx (
      input tick,
      input load,
      input data,
      output hold_free,
      output txd
   );
endinterface
